// ### core/tpu_buf16.v
`timescale 1ns/1ps
`include "tpu_consts.vh"
// Two-byte coherent write buffer with per-byte pending bits
module tpu_buf16 (
   input wire mclk,
   input wire resetn,
   input wire wr_hi,
   input wire wr_lo,
   input wire [7:0] wdata,
   input wire cancel,
   input wire transfer,
   output reg [15:0] value,
   output wire complete
);
   reg pend_hi;
   reg pend_lo;

   assign complete = pend_hi & pend_lo;

   // Pending bits: transfer and cancel clear, new writes set
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pend_hi <= 1'b0;
         pend_lo <= 1'b0;
         value <= 16'h0000;
      end else begin
         if (cancel || transfer) begin
            pend_hi <= 1'b0;
            pend_lo <= 1'b0;
         end else begin
            if (wr_hi) pend_hi <= 1'b1;
            if (wr_lo) pend_lo <= 1'b1;
         end
         // Data held even when cancelled; only the pending bits matter
         if (wr_hi) value[15:8] <= wdata;
         if (wr_lo) value[7:0] <= wdata;
      end
   end
endmodule // tpu_buf16

// ### core/tpu_consts.vh
// Contract
// - Capture-mode read of either value byte latches both bytes until other byte read.
// - Writing a channel status/control register unlatches its read buffer, even in debug.
// - Value writes to a capture-mode channel are discarded.
// - In debug the read-latch state is frozen except for control-write clears.
// - Debug-mode value reads return the live register, not the read buffer.
// - Compare/PWM value writes go to a buffer; move as one 16-bit word.
// - With no clock source the value loads when the second byte is written.
// - Output compare with a clock loads on the next counter change.
// - PWM with a clock loads when counter steps modulo-1 to modulo.
// - High and low bytes accepted in either order.
// - Debug-mode value writes go straight to the register; buffer state frozen.
// - Outside debug, modulo and value byte writes land in buffers.
// - Counter equal to modulo sets overflow flag; interrupt only when enabled.
// - Timer control write discards buffered modulo bytes and resets their logic.
// - Channel control write discards buffered value bytes and resets their logic.
// - Every system reset fully resets the timer.
// - Reset clears timer control: no clock, overflow interrupt off.
// - Reset clears up/down and channel mode/edge bits: capture, pins released.
// - Channel flag sets on capture edge, or on counter match in compare/PWM.
`ifndef TPU_CONSTS_VH
`define TPU_CONSTS_VH
// Timer status/control fields
`define TPU_SC_RESET 8'h00
`define TPU_SC_OVF_FLAG 7
`define TPU_SC_OVF_IE 6
`define TPU_SC_UPDOWN 5
`define TPU_SC_CLKS_HI 4
`define TPU_SC_CLKS_LO 3
`define TPU_SC_PS_HI 2
// Channel status/control fields
`define TPU_CSC_RESET 8'h00
`define TPU_CSC_FLAG 7
`define TPU_CSC_IE 6
`define TPU_CSC_MODE_HI 5
`define TPU_CSC_MODE_LO 4
`define TPU_CSC_EDGE_HI 3
`define TPU_CSC_EDGE_LO 2
// Modes of a channel
`define TPU_MODE_CAPTURE 2'h0
`define TPU_MODE_COMPARE 2'h1
`define TPU_MODE_EDGE_ALIGNED_PWM 2'h2
`define TPU_MODE_CENTER_ALIGNED_PWM 2'h3
`define TPU_CLKS_NONE 2'h0
`define TPU_MOD_RESET 16'h0000
`define TPU_FREE_LAST 16'hFFFF
`endif

// ### core/tpu_rdlatch.v
`timescale 1ns/1ps
`include "tpu_consts.vh"
// Read latch for capture mode; holds both bytes until the second is read
module tpu_rdlatch (
   input wire mclk,
   input wire resetn,
   input wire rd_hi,
   input wire rd_lo,
   input wire capture_mode,
   input wire debug,
   input wire clear,
   input wire [15:0] live,
   output reg [7:0] rdata
);
   reg latched;
   reg first_hi;
   reg [15:0] snap;

   // Latch state; frozen in debug except for clears
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         latched <= 1'b0;
         first_hi <= 1'b0;
         snap <= 16'h0000;
      end else if (clear) begin
         latched <= 1'b0;
      end else if (!debug && capture_mode && (rd_hi || rd_lo)) begin
         if (!latched) begin
            latched <= 1'b1;
            first_hi <= rd_hi;
            snap <= live;
         end else if ((first_hi && rd_lo) || (!first_hi && rd_hi)) begin
            latched <= 1'b0;
         end
      end
   end

   // Read data: buffer when latched, live value in debug
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata <= 8'h00;
      end else if (rd_hi || rd_lo) begin
         if (debug || !capture_mode)
            rdata <= rd_hi ? live[15:8] : live[7:0];
         else if (latched)
            rdata <= rd_hi ? snap[15:8] : snap[7:0];
         else
            rdata <= rd_hi ? live[15:8] : live[7:0];
      end
   end
endmodule // tpu_rdlatch

// ### core/tpu_top.v
`timescale 1ns/1ps
`include "tpu_consts.vh"
// Timer with byte-coherent channel value and modulo registers
module tpu_top #(
   parameter NCH = 2
) (
   input wire mclk,
   input wire resetn,
   input wire debug_halt_mode,
   input wire timer_status_control_wr,
   input wire [7:0] wdata,
   input wire modulo_high_wr,
   input wire modulo_low_wr,
   input wire counter_wr,
   input wire [NCH-1:0] chan_status_control_wr,
   input wire [NCH-1:0] chan_value_high_wr,
   input wire [NCH-1:0] chan_value_low_wr,
   input wire [NCH-1:0] chan_value_high_rd,
   input wire [NCH-1:0] chan_value_low_rd,
   input wire overflow_flag_clr,
   input wire [NCH-1:0] chan_flag_clr,
   input wire [NCH-1:0] chan_pin_in,
   output wire [NCH*8-1:0] chan_rdata,
   output reg [7:0] timer_status_control,
   output reg [15:0] modulo,
   output reg [15:0] counter,
   output wire overflow_irq,
   output reg [NCH*8-1:0] chan_status_control,
   output reg [NCH*16-1:0] chan_value,
   output wire [NCH-1:0] chan_irq,
   output reg [NCH-1:0] chan_pin_out,
   output wire [NCH-1:0] chan_pin_oe_n
);
   localparam PSW = 7;
   reg [PSW-1:0] prescale;
   reg count_dn;
   wire [1:0] clock_source_select;
   wire updown_count_select;
   wire overflow_irq_enable;
   wire clk_on;
   wire [PSW-1:0] ps_limit;
   wire tick;
   wire [15:0] top;
   wire at_top;
   wire [15:0] next_counter;
   wire next_dn;
   wire pwm_edge;
   wire mod_complete;
   wire [15:0] mod_buf;
   wire mod_xfer;
   wire dbg;

   assign dbg = debug_halt_mode;
   assign clock_source_select = {timer_status_control[`TPU_SC_CLKS_HI],
                                 timer_status_control[`TPU_SC_CLKS_LO]};
   assign updown_count_select = timer_status_control[`TPU_SC_UPDOWN];
   assign overflow_irq_enable = timer_status_control[`TPU_SC_OVF_IE];
   assign clk_on = (clock_source_select != `TPU_CLKS_NONE);
   // Prescaler divides by 2^ps, ps in the low three bits
   assign ps_limit = (7'h01 << timer_status_control[`TPU_SC_PS_HI:0]) - 7'h01;
   assign tick = clk_on && !dbg && (prescale == ps_limit);
   assign top = (modulo == `TPU_MOD_RESET) ? `TPU_FREE_LAST : modulo;
   assign at_top = (counter == top);

   // Counter stepping: up count wraps at top, up/down turns round
   assign next_dn = updown_count_select ? (at_top ? 1'b1 : (counter == 16'h0001 ? 1'b0 : count_dn)) : 1'b0;
   assign next_counter = updown_count_select ? (count_dn && counter != 16'h0000 ? counter - 16'h0001
                         : (at_top ? counter - 16'h0001 : counter + 16'h0001))
                         : (at_top ? 16'h0000 : counter + 16'h0001);
   // Step from top-1 to top; free running gives FFFE to FFFF
   assign pwm_edge = tick && !count_dn && (counter == top - 16'h0001);

   // Timer status/control register and overflow flag
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         timer_status_control <= `TPU_SC_RESET;
      end else begin
         if (timer_status_control_wr)
            timer_status_control[6:0] <= wdata[6:0];
         // Set beats clear so a late wrap is never lost
         if (tick && at_top && !(updown_count_select && !count_dn && counter == 16'h0000))
            timer_status_control[`TPU_SC_OVF_FLAG] <= 1'b1;
         else if (overflow_flag_clr)
            timer_status_control[`TPU_SC_OVF_FLAG] <= 1'b0;
      end
   end
   assign overflow_irq = timer_status_control[`TPU_SC_OVF_FLAG] & overflow_irq_enable;

   // Prescaler and main counter
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prescale <= {PSW{1'b0}};
         counter <= 16'h0000;
         count_dn <= 1'b0;
      end else if (counter_wr) begin
         prescale <= {PSW{1'b0}};
         counter <= 16'h0000;
         count_dn <= 1'b0;
      end else if (clk_on && !dbg) begin
         prescale <= tick ? {PSW{1'b0}} : prescale + 7'h01;
         if (tick) begin
            counter <= next_counter;
            count_dn <= next_dn;
         end
      end
   end

   // Modulo buffer: direct in debug, otherwise buffered
   tpu_buf16 u_mod (
      .mclk(mclk),
      .resetn(resetn),
      .wr_hi(modulo_high_wr && !dbg),
      .wr_lo(modulo_low_wr && !dbg),
      .wdata(wdata),
      .cancel(timer_status_control_wr),
      .transfer(mod_xfer),
      .value(mod_buf),
      .complete(mod_complete)
   );
   assign mod_xfer = mod_complete && (!clk_on || (tick && at_top));

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         modulo <= `TPU_MOD_RESET;
      end else if (dbg && modulo_high_wr) begin
         modulo[15:8] <= wdata;
      end else if (dbg && modulo_low_wr) begin
         modulo[7:0] <= wdata;
      end else if (mod_xfer) begin
         modulo <= mod_buf;
      end
   end

   // Per-channel logic
   genvar n;
   generate
      for (n = 0; n < NCH; n = n + 1) begin : g_ch
         wire [1:0] mode;
         wire [1:0] edge_sel;
         wire capture;
         wire complete;
         wire [15:0] buf_val;
         wire xfer;
         wire load_ok;
         reg pin_d;
         wire rise;
         wire fall;
         wire cap_event;
         wire match;
         assign mode = chan_status_control[n*8+`TPU_CSC_MODE_HI -: 2];
         assign edge_sel = chan_status_control[n*8+`TPU_CSC_EDGE_HI -: 2];
         // Up/down counting forces center-aligned behaviour; software keeps it so
         assign capture = (mode == `TPU_MODE_CAPTURE) && !updown_count_select;

         // Mode picks the transfer moment
         assign load_ok = !clk_on ? 1'b1
                        : (mode == `TPU_MODE_COMPARE && !updown_count_select) ? tick
                        : pwm_edge;
         assign xfer = complete && load_ok && !capture;

         tpu_buf16 u_buf (
            .mclk(mclk),
            .resetn(resetn),
            .wr_hi(chan_value_high_wr[n] && !capture && !dbg),
            .wr_lo(chan_value_low_wr[n] && !capture && !dbg),
            .wdata(wdata),
            .cancel(chan_status_control_wr[n]),
            .transfer(xfer),
            .value(buf_val),
            .complete(complete)
         );

         tpu_rdlatch u_rd (
            .mclk(mclk),
            .resetn(resetn),
            .rd_hi(chan_value_high_rd[n]),
            .rd_lo(chan_value_low_rd[n]),
            .capture_mode(capture),
            .debug(dbg),
            .clear(chan_status_control_wr[n]),
            .live(chan_value[n*16 +: 16]),
            .rdata(chan_rdata[n*8 +: 8])
         );

         assign rise = chan_pin_in[n] && !pin_d;
         assign fall = !chan_pin_in[n] && pin_d;
         assign cap_event = capture && ((edge_sel[0] && rise) || (edge_sel[1] && fall));
         assign match = !capture && tick && (next_counter == chan_value[n*16 +: 16]);

         // Control register, flag, value register and pin
         always @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               chan_status_control[n*8 +: 8] <= `TPU_CSC_RESET;
               chan_value[n*16 +: 16] <= 16'h0000;
               chan_pin_out[n] <= 1'b0;
               pin_d <= 1'b0;
            end else begin
               pin_d <= chan_pin_in[n];
               if (chan_status_control_wr[n])
                  chan_status_control[n*8 +: 7] <= wdata[6:0];
               if (cap_event || match)
                  chan_status_control[n*8+`TPU_CSC_FLAG] <= 1'b1;
               else if (chan_flag_clr[n])
                  chan_status_control[n*8+`TPU_CSC_FLAG] <= 1'b0;
               if (cap_event)
                  chan_value[n*16 +: 16] <= counter;
               else if (dbg && !capture && chan_value_high_wr[n])
                  chan_value[n*16+8 +: 8] <= wdata;
               else if (dbg && !capture && chan_value_low_wr[n])
                  chan_value[n*16 +: 8] <= wdata;
               else if (xfer)
                  chan_value[n*16 +: 16] <= buf_val;
               // Toggle on match in compare, set at wrap and clear on match in PWM
               if (match && mode == `TPU_MODE_COMPARE)
                  chan_pin_out[n] <= ~chan_pin_out[n];
               else if (match)
                  chan_pin_out[n] <= 1'b0;
               else if (tick && at_top && mode[1])
                  chan_pin_out[n] <= 1'b1;
            end
         end
         assign chan_irq[n] = chan_status_control[n*8+`TPU_CSC_FLAG] & chan_status_control[n*8+`TPU_CSC_IE];
         // Pin released unless a compare/PWM mode with an edge selected
         assign chan_pin_oe_n[n] = capture || (edge_sel == 2'h0);
      end
   endgenerate
endmodule // tpu_top

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
   typedef struct {int code; logic [15:0] val;} tpu_note_t;
   localparam int NCH = 2;
   logic mclk = 0, resetn = 0, debug_halt_mode = 0, timer_status_control_wr = 0, modulo_high_wr = 0;
   logic modulo_low_wr = 0, counter_wr = 0, overflow_flag_clr = 0, look = 0;
   logic [7:0] wdata = 8'h00;
   logic [NCH-1:0] chan_status_control_wr = '0, chan_value_high_wr = '0, chan_value_low_wr = '0;
   logic [NCH-1:0] chan_value_high_rd = '0, chan_value_low_rd = '0, chan_flag_clr = '0, chan_pin_in = '0;
   wire [NCH*8-1:0] chan_rdata, chan_status_control;
   wire [7:0] timer_status_control;
   wire [15:0] modulo, counter;
   wire [NCH*16-1:0] chan_value;
   wire [NCH-1:0] chan_irq, chan_pin_out, chan_pin_oe_n;
   wire overflow_irq;
   int fails = 0, checked = 0;
   tpu_note_t notes[$];
   tpu_note_t n;
   logic [15:0] v, w;

   always #2 mclk = ~mclk;

   tpu_top #(.NCH(NCH)) i_dut (.mclk, .resetn, .debug_halt_mode, .timer_status_control_wr, .wdata,
      .modulo_high_wr, .modulo_low_wr, .counter_wr, .chan_status_control_wr, .chan_value_high_wr,
      .chan_value_low_wr, .chan_value_high_rd, .chan_value_low_rd, .overflow_flag_clr, .chan_flag_clr,
      .chan_pin_in, .chan_rdata, .timer_status_control, .modulo, .counter, .overflow_irq,
      .chan_status_control, .chan_value, .chan_irq, .chan_pin_out, .chan_pin_oe_n);

   // Watcher: oldest note against the output it names
   always @(posedge mclk) begin
      if (look === 1'b1) begin
         n = notes.pop_front();
         checked++;
         if (pick(n.code) !== n.val) begin
            fails++;
            $display("FAIL %0t: item %0d got %h want %h", $time, n.code, pick(n.code), n.val);
         end
      end
   end

   function automatic logic [15:0] pick(input int c);
      case (c)
         0: pick = chan_value[15:0];
         1: pick = chan_value[31:16];
         2: pick = modulo;
         3: pick = {14'h0000, timer_status_control[7], overflow_irq};
         4: pick = {chan_pin_oe_n, 6'h00, timer_status_control};
         6: pick = counter;
         7: pick = {8'h00, chan_rdata[15:8]};
         8: pick = {8'h00, chan_status_control[15:8]};
         9: pick = {14'h0000, chan_irq};
         default: pick = chan_status_control;
      endcase
   endfunction

   // An idle edge first, then one strobe, one cycle wide
   task put(input int k, input int ch, input logic [7:0] d);
      @(posedge mclk);
      #1;
      wdata = d;
      case (k)
         0: timer_status_control_wr = 1'b1;
         1: modulo_high_wr = 1'b1;
         2: modulo_low_wr = 1'b1;
         3: chan_status_control_wr[ch] = 1'b1;
         4: chan_value_high_wr[ch] = 1'b1;
         5: chan_value_low_wr[ch] = 1'b1;
         6: chan_value_high_rd[ch] = 1'b1;
         7: chan_value_low_rd[ch] = 1'b1;
         9: counter_wr = 1'b1;
         default: overflow_flag_clr = 1'b1;
      endcase
      @(posedge mclk);
      #1;
      {timer_status_control_wr, modulo_high_wr, modulo_low_wr, overflow_flag_clr, counter_wr} = 5'h00;
      {chan_status_control_wr, chan_value_high_wr, chan_value_low_wr, chan_value_high_rd, chan_value_low_rd} = '0;
   endtask

   // Extra cycle first so a load one edge after the strobe has landed
   task note(input int c, input logic [15:0] x);
      notes.push_back('{c, x});
      @(posedge mclk);
      #1;
      look = 1'b1;
      @(posedge mclk);
      #1;
      look = 1'b0;
   endtask

   task wr16(input int ch, input logic [15:0] x, input bit lo_first);
      if (lo_first) begin
         put(5, ch, x[7:0]);
         put(4, ch, x[15:8]);
      end else begin
         put(4, ch, x[15:8]);
         put(5, ch, x[7:0]);
      end
   endtask

   // Pin low for one edge, then high: one rising edge on channel 1
   task pin_rise;
      chan_pin_in = 2'h0;
      @(posedge mclk);
      #1;
      chan_pin_in = 2'h2;
   endtask

   task give_verdict;
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Watchdog, about four times the some 1200 cycles the sequence needs
   initial begin
      #20000;
      fails++;
      give_verdict;
   end

   initial begin
      void'($urandom(93076));
      repeat (10) @(posedge mclk);
      #1;
      resetn = 1'b1;
      note(4, 16'hC000);
      note(5, 16'h0000);
      note(0, 16'h0000);
      put(3, 0, 8'h10);
      // Coherent pairs with clock stopped, both byte orders
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom);
         wr16(0, v, i[0]);
         note(0, v);
      end
      wr16(1, 16'hA5C3, 0);
      note(1, 16'h0000);
      put(6, 1, 8'h00);
      put(7, 1, 8'h00);
      // Control writes drop half-written values
      put(4, 0, 8'hAA);
      put(3, 0, 8'h10);
      put(5, 0, 8'h55);
      note(0, v);
      put(1, 0, 8'hAA);
      put(0, 0, 8'h00);
      put(2, 0, 8'h55);
      note(2, 16'h0000);
      // Debug: writes go straight through, reads are live
      debug_halt_mode = 1'b1;
      put(4, 0, 8'h07);
      note(0, {8'h07, v[7:0]});
      put(6, 0, 8'h00);
      put(1, 0, 8'h00);
      put(2, 0, 8'h07);
      note(2, 16'h0007);
      debug_halt_mode = 1'b0;
      put(3, 0, 8'h10);
      put(0, 0, 8'h08);
      for (int i = 0; i < 40 && timer_status_control[7] !== 1'b1; i++) @(posedge mclk);
      #1;
      note(3, 16'h0002);
      v = 16'($urandom);
      wr16(0, v, 0);
      note(0, v);
      put(0, 0, 8'h40);
      note(3, 16'h0003);
      put(8, 0, 8'h00);
      note(3, 16'h0000);
      // Capture on channel 1: counter stepped twice to 2, then frozen
      put(9, 0, 8'h00);
      put(0, 0, 8'h08);
      put(0, 0, 8'h00);
      note(6, 16'h0002);
      put(3, 1, 8'h44);
      chan_pin_in = 2'h2;
      note(1, 16'h0002);
      note(8, 16'h00C4);
      note(9, 16'h0002);
      // Read latch keeps the first snapshot while a new capture lands
      put(6, 1, 8'h00);
      put(9, 0, 8'h00);
      pin_rise;
      put(7, 1, 8'h00);
      note(7, 16'h0002);
      note(1, 16'h0000);
      // Control write unlatches, so the next read is live
      put(6, 1, 8'h00);
      put(0, 0, 8'h08);
      put(0, 0, 8'h00);
      pin_rise;
      put(3, 1, 8'h44);
      put(7, 1, 8'h00);
      note(7, 16'h0002);
      // Debug read is live and leaves the latch as it was
      put(6, 1, 8'h00);
      put(6, 1, 8'h00);
      put(9, 0, 8'h00);
      pin_rise;
      debug_halt_mode = 1'b1;
      put(7, 1, 8'h00);
      note(7, 16'h0000);
      debug_halt_mode = 1'b0;
      put(7, 1, 8'h00);
      note(7, 16'h0002);
      // Edge-aligned PWM: pair waits for the step from 6 to modulo 7
      put(3, 0, 8'h20);
      put(9, 0, 8'h00);
      put(0, 0, 8'h0F);
      w = 16'($urandom);
      wr16(0, w, 1);
      note(0, v);
      for (int i = 0; i < 1200 && counter !== 16'h0007; i++) @(posedge mclk);
      #1;
      note(0, w);
      give_verdict;
   end
endmodule // tb

// ### test/tpu_properties.sv
`timescale 1ns/1ps
// Port-level checks for the coherent value and modulo buffers
module tpu_checker #(
   parameter NCH = 2
) (
   input wire mclk,
   input wire resetn,
   input wire debug_halt_mode,
   input wire timer_status_control_wr,
   input wire [7:0] wdata,
   input wire modulo_high_wr,
   input wire modulo_low_wr,
   input wire [NCH-1:0] chan_status_control_wr,
   input wire [NCH-1:0] chan_value_high_wr,
   input wire [NCH-1:0] chan_value_low_wr,
   input wire [NCH-1:0] chan_value_high_rd,
   input wire [NCH*8-1:0] chan_rdata,
   input wire [7:0] timer_status_control,
   input wire [15:0] modulo,
   input wire overflow_irq,
   input wire [NCH*8-1:0] chan_status_control,
   input wire [NCH*16-1:0] chan_value,
   input wire [NCH-1:0] chan_pin_oe_n
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Channel 0 buffered write conditions
   wire [1:0] clks = timer_status_control[4:3];
   wire ok0 = chan_status_control[5:4] != 2'h0 && !debug_halt_mode && !chan_status_control_wr[0];

   a_reset_clear: assert property (disable iff (1'b0) $rose(resetn) |-> timer_status_control == 8'h00 &&
      chan_status_control == '0 && modulo == 16'h0000) else $error("state not cleared by reset");
   a_capture_oe_off: assert property (chan_status_control[5:4] == 2'h0 |-> chan_pin_oe_n[0])
      else $error("capture channel drives its pin");
   a_irq_gating: assert property (overflow_irq == (timer_status_control[7] & timer_status_control[6]))
      else $error("overflow request not flag and enable");
   a_flag_needs_clk: assert property ($rose(timer_status_control[7]) |-> $past(clks) != 2'h0)
      else $error("overflow flag set with no clock");
   a_pair_loads: assert property (chan_value_high_wr[0] && ok0 && clks == 2'h0 ##1 !chan_status_control_wr[0]
      ##1 chan_value_low_wr[0] && ok0 && clks == 2'h0 |-> ##2 chan_value[15:0] == {$past(wdata, 4), $past(wdata, 2)})
      else $error("byte pair not loaded as one word");
   a_ctrl_cancel: assert property (chan_value_high_wr[0] && ok0 ##2 chan_status_control_wr[0]
      ##2 chan_value_low_wr[0] && ok0 |=> $stable(chan_value[15:0]) [*2]) else $error("cancelled byte loaded");
   a_mod_cancel: assert property (modulo_high_wr && !debug_halt_mode ##2 timer_status_control_wr
      ##2 modulo_low_wr && !debug_halt_mode |=> $stable(modulo) [*2]) else $error("cancelled modulo byte loaded");
   a_debug_direct: assert property (debug_halt_mode && chan_value_high_wr[0] && chan_status_control[5:4] != 2'h0
      && !chan_status_control_wr[0] |=> chan_value[15:8] == $past(wdata)) else $error("debug write not direct");
   a_debug_live_read: assert property (debug_halt_mode && chan_value_high_rd[0]
      |=> chan_rdata[7:0] == $past(chan_value[15:8])) else $error("debug read not live");
   a_capture_ignore: assert property (chan_status_control[13:10] == 4'h0 && chan_value_high_wr[1]
      |=> $stable(chan_value[31:16])) else $error("capture channel took a write");
endmodule // tpu_checker

bind tpu_top tpu_checker #(.NCH(NCH)) i_chk (.mclk, .resetn, .debug_halt_mode, .timer_status_control_wr, .wdata,
   .modulo_high_wr, .modulo_low_wr, .chan_status_control_wr, .chan_value_high_wr, .chan_value_low_wr,
   .chan_value_high_rd, .chan_rdata, .timer_status_control, .modulo, .overflow_irq, .chan_status_control,
   .chan_value, .chan_pin_oe_n);
